/* design/rcs_top.sv */
// calendar control and status block with its register slave
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_top (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   input  wire logic        calendar_source_clock,
   input  wire logic        prescaled_clock,
   input  wire logic        stamp_pin,
   input  wire logic        tamper1_pin,
   input  wire logic [31:0] cal_time,
   input  wire logic [31:0] cal_date,
   input  wire logic [31:0] cal_subsec,
   input  wire logic        alarm_a_match,
   input  wire logic        alarm_b_match,
   output var  logic        refclk_detect_enable,
   output var  logic        stamp_event,
   output var  logic [31:0] smooth_calibration,
   output var  logic        irq
);

   rcs_pkg::rcs_state_t q;
   rcs_pkg::rcs_state_t next_q;
   rcs_wake_if          wk ();

   logic                cal_tick;
   logic                ck_tick;
   logic                stamp_rise;
   logic                stamp_fall;
   logic                stamp_hit;
   logic                tamper_hit;
   logic                take_rd;
   logic                take_wr;
   logic [31:0]         wmask;
   logic [31:0]         wdat;
   rcs_pkg::rcs_flags_t events;
   rcs_pkg::rcs_flags_t zero_wr;
   logic [31:0]         ctrl_word;
   logic [31:0]         sts_word;

   // ==========================================================
   // helpers
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
      is_addr = (a[7:2] == off[7:2]);
   endfunction : is_addr

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   // ==========================================================
   // pin edges, read only after the second sync stage
   always_comb begin
      cal_tick   = q.calclk_sync[1] && !q.calclk_sync[2];
      ck_tick    = q.ckclk_sync[1] && !q.ckclk_sync[2];
      stamp_rise = q.stamp_sync[1] && !q.stamp_sync[2];
      stamp_fall = !q.stamp_sync[1] && q.stamp_sync[2];
      stamp_hit  = q.stamp_enable && (q.stamp_edge_select ? stamp_fall : stamp_rise);
      tamper_hit = q.tamper_sync[1] && !q.tamper_sync[2];
   end

   // ==========================================================
   // bus decode
   // every access waits exactly one cycle so read data come from a flop
   always_comb begin
      take_rd = read && (q.bus == rcs_pkg::RCS_IDLE);
      take_wr = write && (q.bus == rcs_pkg::RCS_ACK);
      wmask   = lane_mask(byteenable);
      wdat    = writedata & wmask;
   end

   assign waitrequest = (read || write) && (q.bus != rcs_pkg::RCS_ACK);

   // ==========================================================
   // register images
   always_comb begin
      ctrl_word                                         = 32'h0;
      ctrl_word[`RCS_CTRL_WSEL_LSB +: 3]                = q.wakeup_clock_select;
      ctrl_word[`RCS_CTRL_EDGE]                         = q.stamp_edge_select;
      ctrl_word[`RCS_CTRL_REFCLK]                       = q.refclk_detect_enable;
      ctrl_word[`RCS_CTRL_DIRECT]                       = q.direct_read_select;
      ctrl_word[`RCS_CTRL_WAKE_EN]                      = q.wakeup_timer_enable;
      ctrl_word[`RCS_CTRL_STAMP_EN]                     = q.stamp_enable;
      sts_word                                          = 32'h0;
      sts_word[`RCS_STS_WRITE_OK]                       = q.wakeup_write_allowed;
      sts_word[`RCS_STS_FLAG_LSB +: 6]                  = q.flags;
      sts_word[`RCS_STS_CAL_PEND]                       = q.cal_pending;
   end

   // ==========================================================
   // event collection
   always_comb begin
      events    = {tamper_hit,
                   stamp_hit && q.flags[3],
                   stamp_hit,
                   wk.wake_event,
                   alarm_b_match,
                   alarm_a_match};
      zero_wr   = '0;
      if (take_wr && is_addr(address, `RCS_OFF_STS)) begin
         zero_wr = ~writedata[`RCS_STS_FLAG_LSB +: 6] & wmask[`RCS_STS_FLAG_LSB +: 6];
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      next_q = q;

      // synchronisers: stage 0 feeds only stage 1
      next_q.calclk_sync = {q.calclk_sync[1:0], calendar_source_clock};
      next_q.ckclk_sync  = {q.ckclk_sync[1:0], prescaled_clock};
      next_q.stamp_sync  = {q.stamp_sync[1:0], stamp_pin};
      next_q.tamper_sync = {q.tamper_sync[1:0], tamper1_pin};

      // shadow copies refresh on every second source edge
      if (cal_tick) begin
         next_q.half = !q.half;
         if (q.half) begin
            next_q.shadow_time = cal_time;
            next_q.shadow_date = cal_date;
            next_q.shadow_sub  = cal_subsec;
         end
      end

      // bus handshake
      unique case (q.bus)
         rcs_pkg::RCS_IDLE: begin
            if (read || write) begin
               next_q.bus = rcs_pkg::RCS_ACK;
            end
         end
         rcs_pkg::RCS_ACK: begin
            next_q.bus = rcs_pkg::RCS_IDLE;
         end
         default: begin
            next_q.bus = rcs_pkg::RCS_IDLE;
         end
      endcase

      if (take_rd) begin
         next_q.rdata = 32'h0;
         if (is_addr(address, `RCS_OFF_TIME)) begin
            next_q.rdata = q.direct_read_select ? cal_time : q.shadow_time;
         end else if (is_addr(address, `RCS_OFF_DATE)) begin
            next_q.rdata = q.direct_read_select ? cal_date : q.shadow_date;
         end else if (is_addr(address, `RCS_OFF_SUBSEC)) begin
            next_q.rdata = q.direct_read_select ? cal_subsec : q.shadow_sub;
         end else if (is_addr(address, `RCS_OFF_CTRL)) begin
            next_q.rdata = ctrl_word;
         end else if (is_addr(address, `RCS_OFF_STS)) begin
            next_q.rdata = sts_word;
         end else if (is_addr(address, `RCS_OFF_WAKE)) begin
            next_q.rdata = {16'h0, q.reload};
         end else if (is_addr(address, `RCS_OFF_SCAL)) begin
            next_q.rdata = q.smooth_cal;
         end else if (is_addr(address, `RCS_OFF_IRQ_MASK)) begin
            next_q.rdata = {26'h0, q.irq_mask};
         end else if (is_addr(address, `RCS_OFF_IRQ_STAT)) begin
            next_q.rdata = {26'h0, q.irq_stat};
         end
      end

      if (take_wr && is_addr(address, `RCS_OFF_CTRL)) begin
         if (wmask[`RCS_CTRL_DIRECT]) begin
            next_q.direct_read_select = wdat[`RCS_CTRL_DIRECT];
         end
         if (wmask[`RCS_CTRL_REFCLK]) begin
            next_q.refclk_detect_enable = wdat[`RCS_CTRL_REFCLK];
         end
         if (wmask[`RCS_CTRL_EDGE]) begin
            next_q.stamp_edge_select = wdat[`RCS_CTRL_EDGE];
         end
         // judged on the state before this write, so enabling and selecting in one go is accepted
         if (wmask[`RCS_CTRL_WSEL_LSB] && !q.wakeup_timer_enable && q.wakeup_write_allowed) begin
            next_q.wakeup_clock_select = wdat[`RCS_CTRL_WSEL_LSB +: 3];
         end
         if (wmask[`RCS_CTRL_WAKE_EN]) begin
            next_q.wakeup_timer_enable = wdat[`RCS_CTRL_WAKE_EN];
         end
         if (wmask[`RCS_CTRL_STAMP_EN]) begin
            next_q.stamp_enable = wdat[`RCS_CTRL_STAMP_EN];
         end
      end

      if (take_wr && is_addr(address, `RCS_OFF_WAKE) && !q.wakeup_timer_enable && q.wakeup_write_allowed) begin
         next_q.reload = 16'(merge({16'h0, q.reload}, writedata, wmask));
      end

      // allowed flag follows the enable in the same cycle
      next_q.wakeup_write_allowed = !next_q.wakeup_timer_enable;

      // calibration value applies at once; the next source tick clears cal_pending
      if (cal_tick) begin
         next_q.cal_pending = 1'b0;
      end
      if (take_wr && is_addr(address, `RCS_OFF_SCAL) && !q.cal_pending) begin
         next_q.smooth_cal  = merge(q.smooth_cal, writedata, wmask);
         next_q.cal_pending = 1'b1;
      end

      // cleared zeros travel two stages; a fresh event beats a clear
      next_q.clr_p1 = zero_wr;
      next_q.clr_p2 = q.clr_p1;
      next_q.flags  = (q.flags & ~q.clr_p2) | events;

      // interrupt status: sticky, write one to clear, set wins
      if (take_wr && is_addr(address, `RCS_OFF_IRQ_MASK)) begin
         next_q.irq_mask = 6'(merge({26'h0, q.irq_mask}, writedata, wmask));
      end
      next_q.irq_stat = q.irq_stat;
      if (take_wr && is_addr(address, `RCS_OFF_IRQ_STAT)) begin
         next_q.irq_stat = q.irq_stat & ~(writedata[5:0] & wmask[5:0]);
      end
      next_q.irq_stat = next_q.irq_stat | events;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q                      <= '0;
         q.reload               <= `RCS_WAKE_RELOAD_RST;
         q.wakeup_write_allowed <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ==========================================================
   // wakeup counter
   assign wk.enable         = q.wakeup_timer_enable;
   assign wk.clock_select   = q.wakeup_clock_select;
   assign wk.reload         = q.reload;
   assign wk.cal_tick       = cal_tick;
   assign wk.prescaled_tick = ck_tick;

   rcs_wakeup u_wakeup (
      .clk  (clk),
      .nrst (nrst),
      .wk   (wk.timer)
   );

   // ==========================================================
   // outputs
   assign readdata             = q.rdata;
   assign refclk_detect_enable = q.refclk_detect_enable;
   assign stamp_event          = q.flags[3];
   assign smooth_calibration   = q.smooth_cal;
   assign irq                  = |(q.irq_stat & q.irq_mask);

endmodule : rcs_top

`default_nettype wire

/* design/rcs_regs.svh */
// register map, field positions, reset values and timing counts of the calendar control block
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

`define RCS_OFF_TIME          8'h00
`define RCS_OFF_DATE          8'h04
`define RCS_OFF_CTRL          8'h08
`define RCS_OFF_STS           8'h0c
`define RCS_OFF_WAKE          8'h14
`define RCS_OFF_SUBSEC        8'h28
`define RCS_OFF_SCAL          8'h3c
`define RCS_OFF_IRQ_MASK      8'h40
`define RCS_OFF_IRQ_STAT      8'h44

`define RCS_CTRL_WSEL_LSB     0
`define RCS_CTRL_EDGE         3
`define RCS_CTRL_REFCLK       4
`define RCS_CTRL_DIRECT       5
`define RCS_CTRL_WAKE_EN      10
`define RCS_CTRL_STAMP_EN     11

`define RCS_STS_WRITE_OK      2
`define RCS_STS_FLAG_LSB      8
`define RCS_STS_CAL_PEND      16

`define RCS_WAKE_RELOAD_RST   16'hffff
`define RCS_CLR_DELAY         2
`define RCS_SHADOW_EDGES      2
`define RCS_WAKE_EXTEND       17'h10000

`endif

/* design/rcs_pkg.sv */
// types of the calendar control block
package rcs_pkg;

   // flag order: tamper1, overflow, stamp, wakeup, alarm b, alarm a
   typedef logic [5:0] rcs_flags_t;

   typedef enum logic [1:0] {
      RCS_IDLE = 2'b00,
      RCS_ACK  = 2'b01
   } rcs_bus_state_t;

   typedef struct packed {
      rcs_bus_state_t bus;
      logic [31:0]    rdata;
      logic           direct_read_select;
      logic           refclk_detect_enable;
      logic           stamp_edge_select;
      logic [2:0]     wakeup_clock_select;
      logic           wakeup_timer_enable;
      logic           stamp_enable;
      logic           wakeup_write_allowed;
      logic [15:0]    reload;
      logic [31:0]    smooth_cal;
      logic           cal_pending;
      rcs_flags_t     flags;
      rcs_flags_t     clr_p1;
      rcs_flags_t     clr_p2;
      logic [2:0]     calclk_sync;
      logic [2:0]     ckclk_sync;
      logic [2:0]     stamp_sync;
      logic [2:0]     tamper_sync;
      logic           half;
      logic [31:0]    shadow_time;
      logic [31:0]    shadow_date;
      logic [31:0]    shadow_sub;
      rcs_flags_t     irq_mask;
      rcs_flags_t     irq_stat;
   } rcs_state_t;

   typedef struct packed {
      logic        enable;
      logic [16:0] count;
      logic [3:0]  div;
   } rcs_wake_state_t;

endpackage : rcs_pkg

/* design/rcs_wake_if.sv */
// carrier between the control block and its wakeup counter
`timescale 1ns/1ps
`default_nettype none

interface rcs_wake_if;
   logic        enable;
   logic [2:0]  clock_select;
   logic [15:0] reload;
   logic        cal_tick;
   logic        prescaled_tick;
   logic        wake_event;

   modport ctrl (
      output enable,
      output clock_select,
      output reload,
      output cal_tick,
      output prescaled_tick,
      input  wake_event
   );

   modport timer (
      input  enable,
      input  clock_select,
      input  reload,
      input  cal_tick,
      input  prescaled_tick,
      output wake_event
   );
endinterface : rcs_wake_if

`default_nettype wire

/* design/rcs_wakeup.sv */
// wakeup down-counter with selectable tick source
`timescale 1ns/1ps
`default_nettype none

module rcs_wakeup (
   input  wire logic  clk,
   input  wire logic  nrst,
   rcs_wake_if.timer  wk
);

   rcs_pkg::rcs_wake_state_t q;
   rcs_pkg::rcs_wake_state_t next_q;
   logic                     tick;
   logic [16:0]              load_val;
   logic                     evt;

   // ==========================================================
   // tick source and reload
   always_comb begin
      unique case (wk.clock_select[1:0])
         2'b00: tick = wk.cal_tick && (q.div == 4'hf);
         2'b01: tick = wk.cal_tick && (q.div[2:0] == 3'h7);
         2'b10: tick = wk.cal_tick && (q.div[1:0] == 2'h3);
         2'b11: tick = wk.cal_tick && q.div[0];
      endcase
      if (wk.clock_select[2]) begin
         tick = wk.prescaled_tick;
      end
      // 11x stretches the interval by a full 16-bit span
      if (wk.clock_select[2] && wk.clock_select[1]) begin
         load_val = {1'b0, wk.reload} + `RCS_WAKE_EXTEND;
      end else begin
         load_val = {1'b0, wk.reload};
      end
   end

   // ==========================================================
   // counter
   always_comb begin
      next_q        = q;
      evt           = 1'b0;
      next_q.enable = wk.enable;
      if (wk.cal_tick) begin
         next_q.div = q.div + 4'h1;
      end
      if (!wk.enable) begin
         next_q.div   = 4'h0;
         next_q.count = load_val;
      end else if (!q.enable) begin
         next_q.count = load_val;
      end else if (tick) begin
         if (q.count == 17'h0) begin
            evt          = 1'b1;
            next_q.count = load_val;
         end else begin
            next_q.count = q.count - 17'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign wk.wake_event = evt;

endmodule : rcs_wakeup

`default_nettype wire

/* sim/rcs_top_chk.sv */
// port assertions for the calendar control block
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_top_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        stamp_pin,
   input wire logic        refclk_detect_enable,
   input wire logic        stamp_event,
   input wire logic [31:0] smooth_calibration,
   input wire logic        irq
);
   // ======================================
   // helpers
   logic wr_done;
   logic [7:0] wa;
   logic stamp_clr;
   assign wr_done = write && !waitrequest;
   assign wa = address & 8'hfc;
   assign stamp_clr = wr_done && wa == `RCS_OFF_STS && byteenable[1] && !writedata[11];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ======================================
   // bus handshake
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one cycle");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high with no request");
   a_read_load: assert property (!$stable(readdata) |-> $past(read && waitrequest))
      else $error("readdata moved outside a read");

   // ======================================
   // control and status
   a_refclk_write: assert property (
      wr_done && wa == `RCS_OFF_CTRL && byteenable[0] |=> refclk_detect_enable == $past(writedata[4]))
      else $error("refclk enable not written");
   a_refclk_cause: assert property (
      !$stable(refclk_detect_enable) |-> $past(wr_done && wa == `RCS_OFF_CTRL))
      else $error("refclk enable moved without write");
   a_scal_cause: assert property (
      !$stable(smooth_calibration) |-> $past(wr_done && wa == `RCS_OFF_SCAL))
      else $error("calibration moved without write");
   a_clear_holds: assert property (
      stamp_clr && stamp_event |=> stamp_event [*2])
      else $error("stamp flag cleared too early");
   a_stamp_fall: assert property (
      $fell(stamp_event) |-> $past(stamp_clr, 3))
      else $error("stamp flag fell without clear");
   a_stamp_rise: assert property (
      $rose(stamp_event) |-> $past(stamp_pin, 1) != $past(stamp_pin, 6))
      else $error("stamp flag rose without pin edge");

   c_stamp_clear: cover property ($fell(stamp_event));
   c_scal_write: cover property (!$stable(smooth_calibration));
   c_irq_up: cover property ($rose(irq));
endmodule : rcs_top_chk

bind rcs_top rcs_top_chk u_rcs_top_chk (.clk, .nrst, .address, .read, .write, .writedata, .byteenable,
   .readdata, .waitrequest, .stamp_pin, .refclk_detect_enable, .stamp_event, .smooth_calibration, .irq);

`default_nettype wire

/* sim/rcs_top_test.sv */
// self-checking bench of the calendar control block
`timescale 1ns/1ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_top_test;
   logic        clk;
   logic        nrst;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [5:0]  pin;
   logic [31:0] cal [3];
   logic        refclk_detect_enable;
   logic        stamp_event;
   logic [31:0] smooth_calibration;
   logic        irq;
   logic [31:0] rv;
   logic [7:0]  offs [3];
   int          n_mismatch;
   int          num_checks;

   // ======================================
   // device
   // pin: 0 source clock, 1 prescaled, 2 stamp, 3 tamper, 4 alarm a, 5 alarm b
   rcs_top u_rcs_top (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .calendar_source_clock(pin[0]), .prescaled_clock(pin[1]), .stamp_pin(pin[2]),
      .tamper1_pin(pin[3]), .cal_time(cal[0]), .cal_date(cal[1]), .cal_subsec(cal[2]),
      .alarm_a_match(pin[4]), .alarm_b_match(pin[5]), .refclk_detect_enable(refclk_detect_enable),
      .stamp_event(stamp_event), .smooth_calibration(smooth_calibration), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ======================================
   // tasks
   task automatic wrap_up();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // request stands until waitrequest is seen low at a rising edge; read before that edge's updates land
   task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !rw;
      write <= rw;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rv = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one idle edge so a following call never reassigns the strobe in this time step
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      bus(1'b1, a, d, be);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(nm, rv, e);
   endtask : rc

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask : tk

   task automatic pulse(input int i);
      pin[i] <= 1'b1;
      tk(5);
      pin[i] <= 1'b0;
      tk(5);
   endtask : pulse

   // ======================================
   // watchdog, whole run is a few hundred cycles
   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   // ======================================
   // tests
   initial begin
      nrst = 1'b0;
      address = 8'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
      pin = 6'h0;
      cal = '{32'h0, 32'h0, 32'h0};
      offs = '{`RCS_OFF_TIME, `RCS_OFF_DATE, `RCS_OFF_SUBSEC};
      n_mismatch = 0;
      num_checks = 0;
      tk(5);
      nrst <= 1'b1;
      tk(1);
      rc(`RCS_OFF_CTRL, 32'h0, "ctrl");
      rc(`RCS_OFF_STS, 32'h4, "sts");
      rc(`RCS_OFF_WAKE, 32'hffff, "reload");
      rc(8'h80, 32'h0, "unmapped");
      wr(`RCS_OFF_CTRL, 32'h3f);
      rc(`RCS_OFF_CTRL, 32'h3f, "ctrl");
      chk("refclk", {31'h0, refclk_detect_enable}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(`RCS_OFF_CTRL, i);
         rc(`RCS_OFF_CTRL, i, "wsel");
      end
      wr(`RCS_OFF_IRQ_MASK, 32'h3f);
      // extended count: reload 0 must not fire after a few ticks
      wr(`RCS_OFF_WAKE, 32'h0);
      wr(`RCS_OFF_CTRL, 32'h406);
      rc(`RCS_OFF_STS, 32'h0, "sts");
      wr(`RCS_OFF_CTRL, 32'h405);
      rc(`RCS_OFF_CTRL, 32'h406, "ctrl");
      wr(`RCS_OFF_WAKE, 32'h9);
      rc(`RCS_OFF_WAKE, 32'h0, "reload");
      repeat (3) pulse(1);
      rc(`RCS_OFF_STS, 32'h0, "sts");
      wr(`RCS_OFF_CTRL, 32'h0);
      wr(`RCS_OFF_WAKE, 32'h2);
      wr(`RCS_OFF_CTRL, 32'h404);
      repeat (2) pulse(1);
      rc(`RCS_OFF_STS, 32'h0, "sts");
      pulse(1);
      rc(`RCS_OFF_STS, 32'h400, "sts");
      chk("irq", {31'h0, irq}, 32'h1);
      wr(`RCS_OFF_STS, 32'hfffffbff);
      tk(2);
      rc(`RCS_OFF_STS, 32'h0, "sts");
      wr(`RCS_OFF_IRQ_STAT, 32'h3f);
      chk("irq", {31'h0, irq}, 32'h0);
      // timestamp, overflow and delayed clear
      wr(`RCS_OFF_CTRL, 32'h800);
      pulse(2);
      rc(`RCS_OFF_STS, 32'h804, "sts");
      chk("stamp", {31'h0, stamp_event}, 32'h1);
      pulse(2);
      rc(`RCS_OFF_STS, 32'h1804, "sts");
      wr(`RCS_OFF_STS, 32'hfffff7ff);
      chk("stamp", {31'h0, stamp_event}, 32'h1);
      tk(2);
      rc(`RCS_OFF_STS, 32'h1004, "sts");
      wr(`RCS_OFF_STS, 32'hffffefff);
      tk(2);
      rc(`RCS_OFF_STS, 32'h4, "sts");
      wr(`RCS_OFF_CTRL, 32'h808);
      pin[2] <= 1'b1;
      tk(6);
      rc(`RCS_OFF_STS, 32'h4, "sts");
      pin[2] <= 1'b0;
      tk(6);
      rc(`RCS_OFF_STS, 32'h804, "sts");
      pulse(3);
      pulse(4);
      pulse(5);
      rc(`RCS_OFF_STS, 32'h2b04, "sts");
      wr(`RCS_OFF_STS, 32'h0, 4'h1);
      tk(3);
      rc(`RCS_OFF_STS, 32'h2b04, "sts");
      wr(`RCS_OFF_STS, 32'h0, 4'h2);
      tk(2);
      rc(`RCS_OFF_STS, 32'h4, "sts");
      // interrupt masking and clearing
      chk("irq", {31'h0, irq}, 32'h1);
      wr(`RCS_OFF_IRQ_MASK, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(`RCS_OFF_IRQ_MASK, 32'h3f);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(`RCS_OFF_IRQ_STAT, 32'h3f);
      chk("irq", {31'h0, irq}, 32'h0);
      rc(`RCS_OFF_IRQ_STAT, 32'h0, "irqstat");
      // shadow versus direct calendar reads
      for (int k = 0; k < 3; k++) cal[k] <= 32'h1000 + k;
      repeat (2) pulse(0);
      for (int k = 0; k < 3; k++) cal[k] <= 32'h2000 + k;
      tk(1);
      for (int k = 0; k < 3; k++) rc(offs[k], 32'h1000 + k, "shadow");
      wr(`RCS_OFF_CTRL, 32'h20);
      for (int k = 0; k < 3; k++) rc(offs[k], 32'h2000 + k, "direct");
      // calibration update handshake
      wr(`RCS_OFF_SCAL, 32'h1234);
      chk("scal", smooth_calibration, 32'h1234);
      rc(`RCS_OFF_STS, 32'h10004, "sts");
      wr(`RCS_OFF_SCAL, 32'h5678);
      chk("scal", smooth_calibration, 32'h1234);
      pulse(0);
      rc(`RCS_OFF_STS, 32'h4, "sts");
      wr(`RCS_OFF_SCAL, 32'h5678);
      chk("scal", smooth_calibration, 32'h5678);
      // source clock halved, reload 0: event on the second source tick
      wr(`RCS_OFF_WAKE, 32'h0);
      wr(`RCS_OFF_CTRL, 32'h403);
      pulse(0);
      rc(`RCS_OFF_STS, 32'h0, "sts");
      pulse(0);
      rc(`RCS_OFF_STS, 32'h400, "sts");
      wrap_up();
   end
endmodule : rcs_top_test

`default_nettype wire
